// [pkg/rmt_pkg.sv]
// Purpose: Shared constants of the RAM ECC test-mode block.
// Assumes: Byte data guarded by a 4-bit check code and one overall parity bit.
// Notes: The stored word layout matches the inversion register layout.
package rmt_pkg;
    localparam int DATA_W = 8;
    localparam int CHK_W = 4;
    localparam int WORD_W = 13;
    localparam int INV_DATA_LSB = 0;
    localparam int INV_CHK_LSB = 8;
    localparam int INV_PAR_BIT = 12;
    localparam logic [2:0] KEY_UNLOCK = 3'h7;
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_TEST = 3'h1;
    localparam logic [2:0] KEY_RST = 3'h0;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [12:0] INV_RST = 13'h0000;
    localparam logic [12:0] WORD_RST = 13'h0000;
    localparam logic NOTIFY_RST = 1'b0;
    localparam logic ERR_TYPE_RST = 1'b0;
    localparam logic [15:0] ERR_ADDR_RST = 16'h0000;
    localparam logic [7:0] RDATA_RST = 8'h00;
    // Syndrome column of data bit j sits at bits [4j+3:4j]; check bit i has column 1<<i.
    localparam logic [31:0] H_COLS = {4'hC, 4'hB, 4'hA, 4'h9, 4'h7, 4'h6, 4'h5, 4'h3};
endpackage

// [src/rmt_ram_ecc_test.sv]
// Purpose: Protected internal RAM with SEC-DED check and write-inversion test mode.
// Assumes: One RAM access per cycle from the CPU; registers written by plain strobes.
// Notes: Read data and error reporting appear one cycle after the read is taken.
// Functional notes
// - Single-error notify enable written 00H or 01H.
// - Key 07H unlocks the mode select register.
// - Mode select 01H enters test mode.
// - Test-mode writes invert the selected stored bits.
// - Mode select 00H returns to normal.
// - Key 00H relocks the mode select register.
// - Reading corrupted location updates flag, type, address; here a parity-bit-only error updates none of them.
// - Single error corrected; reported only when enabled.
// - Double error always reported with type one.
// - Three or more inverted bits give undefined results.
// - Type bit zero single, one double.
// - Double error ignores the single-error enable.
// - Inversion register: parity, four check, eight data.
// - Mode code 000B normal, 001B test.
`timescale 1ns/1ps
`default_nettype none
module rmt_ram_ecc_test
    import rmt_pkg::*;
#(
    parameter int IDX_W = 4,
    parameter int ADDR_W = 16
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic notify_wr,
    input wire logic [7:0] notify_wdata,
    input wire logic key_wr,
    input wire logic [7:0] key_wdata,
    input wire logic mode_wr,
    input wire logic [7:0] mode_wdata,
    input wire logic inv_wr,
    input wire logic [15:0] inv_wdata,
    input wire logic irq_flag_clr,
    input wire logic ram_req,
    input wire logic ram_we,
    input wire logic [ADDR_W-1:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    output logic [7:0] ram_rdata_q,
    output logic ram_rvalid_q,
    output logic single_err_notify_en_q,
    output logic [2:0] test_protect_key_q,
    output logic [2:0] test_mode_code_q,
    output logic [7:0] data_invert_mask_q,
    output logic [3:0] check_code_invert_mask_q,
    output logic parity_invert_q,
    output logic double_error_flag_q,
    output logic [ADDR_W-1:0] error_address_reg_q,
    output logic ram_error_irq_flag_q,
    output logic ram_error_request_q
);
    localparam int DEPTH = 1 << IDX_W;

    logic [12:0] inv_q;
    logic [12:0] mem_q [DEPTH];
    logic [IDX_W-1:0] idx;
    logic unlocked;
    logic test_active;
    logic [12:0] enc_word;
    logic [12:0] wr_mask;
    logic [12:0] wr_word;
    logic [12:0] rd_word;
    logic [7:0] dec_data;
    logic dec_single;
    logic dec_double;
    logic dec_parity_only;
    logic wr_fire;
    logic rd_fire;
    logic report;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    assign unlocked = (test_protect_key_q == KEY_UNLOCK);
    assign test_active = (test_mode_code_q == MODE_TEST);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            single_err_notify_en_q <= NOTIFY_RST;
        end else if (ce && notify_wr) begin
            single_err_notify_en_q <= notify_wdata[0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            test_protect_key_q <= KEY_RST;
        end else if (ce && key_wr) begin
            test_protect_key_q <= key_wdata[2:0];
        end
    end

    // A locked write is dropped silently, which is what keeps a runaway store from
    // corrupting RAM writes.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            test_mode_code_q <= MODE_RST;
        end else if (ce && mode_wr && unlocked) begin
            test_mode_code_q <= mode_wdata[2:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            inv_q <= INV_RST;
        end else if (ce && inv_wr) begin
            inv_q <= inv_wdata[12:0];
        end
    end

    assign data_invert_mask_q = inv_q[INV_DATA_LSB+:8];
    assign check_code_invert_mask_q = inv_q[INV_CHK_LSB+:4];
    assign parity_invert_q = inv_q[INV_PAR_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Storage and code.

    assign idx = ram_addr[IDX_W-1:0];
    assign wr_fire = ce && ram_req && ram_we;
    assign rd_fire = ce && ram_req && !ram_we;
    assign wr_mask = test_active ? inv_q : 13'h0000;
    assign wr_word = enc_word ^ wr_mask;
    assign rd_word = mem_q[idx];

    rmt_secded u_code (
        .enc_data(ram_wdata),
        .enc_word(enc_word),
        .dec_word(rd_word),
        .dec_data(dec_data),
        .dec_single(dec_single),
        .dec_double(dec_double),
        .dec_parity_only(dec_parity_only)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= WORD_RST;
            end
        end else if (wr_fire) begin
            mem_q[idx] <= wr_word;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ram_rdata_q <= RDATA_RST;
            ram_rvalid_q <= 1'b0;
        end else if (ce) begin
            ram_rvalid_q <= rd_fire;
            if (rd_fire) begin
                ram_rdata_q <= dec_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Error reporting. Three or more flipped bits alias onto these cases and are
    // reported however the code happens to see them.

    assign report = rd_fire && ((dec_single && single_err_notify_en_q) || dec_double);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            double_error_flag_q <= ERR_TYPE_RST;
            error_address_reg_q <= ERR_ADDR_RST[ADDR_W-1:0];
        end else if (report) begin
            double_error_flag_q <= dec_double;
            error_address_reg_q <= ram_addr;
        end
    end

    // The set beats a clear in the same cycle so no error is lost.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ram_error_irq_flag_q <= 1'b0;
            ram_error_request_q <= 1'b0;
        end else if (ce) begin
            ram_error_request_q <= report;
            if (report) begin
                ram_error_irq_flag_q <= 1'b1;
            end else if (irq_flag_clr) begin
                ram_error_irq_flag_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_lock_guard: assert property (@(posedge clock) disable iff (rst)
        ce && mode_wr && !unlocked |=> $stable(test_mode_code_q))
        else $error("mode select changed while locked");

    a_mode_enter: assert property (@(posedge clock) disable iff (rst)
        ce && mode_wr && unlocked && mode_wdata[2:0] == MODE_TEST |=> test_active)
        else $error("test mode not entered");

    a_mode_leave: assert property (@(posedge clock) disable iff (rst)
        ce && mode_wr && unlocked && mode_wdata[2:0] == MODE_NORMAL |=> !test_active)
        else $error("test mode not left");

    a_key_relock: assert property (@(posedge clock) disable iff (rst)
        ce && key_wr && key_wdata[2:0] != KEY_UNLOCK |=> !unlocked)
        else $error("key did not relock");

    a_invert_store: assert property (@(posedge clock) disable iff (rst)
        wr_fire && test_active |=> mem_q[$past(idx)] == ($past(enc_word) ^ $past(inv_q)))
        else $error("inverted word not stored");

    a_plain_store: assert property (@(posedge clock) disable iff (rst)
        wr_fire && !test_active |=> mem_q[$past(idx)] == $past(enc_word))
        else $error("normal write modified");

    a_single_report: assert property (@(posedge clock) disable iff (rst)
        rd_fire && dec_single && single_err_notify_en_q |=> ram_error_request_q
        && ram_error_irq_flag_q && !double_error_flag_q
        && error_address_reg_q == $past(ram_addr))
        else $error("single error not reported");

    a_single_quiet: assert property (@(posedge clock) disable iff (rst)
        rd_fire && dec_single && !single_err_notify_en_q |=> !ram_error_request_q
        && $stable(error_address_reg_q))
        else $error("disabled single error reported");

    a_double_report: assert property (@(posedge clock) disable iff (rst)
        rd_fire && dec_double |=> ram_error_request_q && double_error_flag_q
        && error_address_reg_q == $past(ram_addr))
        else $error("double error not reported");

    a_parity_quiet: assert property (@(posedge clock) disable iff (rst)
        rd_fire && dec_parity_only |=> !ram_error_request_q && ram_rdata_q == $past(rd_word[7:0]))
        else $error("parity-only error misbehaved");

    a_flag_sticky: assert property (@(posedge clock) disable iff (rst)
        ram_error_request_q && !(ce && irq_flag_clr) |=> ram_error_irq_flag_q)
        else $error("flag lost before clear");

    a_inv_fields: assert property (@(posedge clock) disable iff (rst)
        ce && inv_wr |=> parity_invert_q == $past(inv_wdata[12])
        && check_code_invert_mask_q == $past(inv_wdata[11:8])
        && data_invert_mask_q == $past(inv_wdata[7:0]))
        else $error("inversion fields misplaced");
endmodule
`default_nettype wire

// [src/rmt_secded.sv]
// Purpose: Encoder and decoder of the byte SEC-DED code.
// Assumes: Word is {parity, check[3:0], data[7:0]}.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module rmt_secded
    import rmt_pkg::*;
(
    input wire logic [7:0] enc_data,
    output logic [12:0] enc_word,
    input wire logic [12:0] dec_word,
    output logic [7:0] dec_data,
    output logic dec_single,
    output logic dec_double,
    output logic dec_parity_only
);
    logic [3:0] enc_chk;
    logic [3:0] dec_syn;
    logic [7:0] flip;
    logic overall;

    for (genvar gi = 0; gi < CHK_W; gi++) begin : g_chk
        logic [7:0] sel;
        for (genvar gj = 0; gj < DATA_W; gj++) begin : g_sel
            assign sel[gj] = H_COLS[4*gj+gi];
        end
        assign enc_chk[gi] = ^(enc_data & sel);
        assign dec_syn[gi] = (^(dec_word[7:0] & sel)) ^ dec_word[INV_CHK_LSB+gi];
    end

    // Correction follows the syndrome even when the overall parity calls it a double error,
    // so a data bit paired with the parity bit still reads back as written.
    for (genvar gj = 0; gj < DATA_W; gj++) begin : g_flip
        assign flip[gj] = (dec_syn == H_COLS[4*gj+:4]);
    end

    assign enc_word = {^{enc_data, enc_chk}, enc_chk, enc_data};
    assign overall = ^dec_word;
    assign dec_data = dec_word[7:0] ^ flip;
    assign dec_single = (dec_syn != 4'h0) && overall;
    assign dec_double = (dec_syn != 4'h0) && !overall;
    assign dec_parity_only = (dec_syn == 4'h0) && overall;
endmodule
`default_nettype wire

// [tb/rmt_cpu_model.sv]
// Purpose: CPU-side model that programs the test registers and makes RAM cycles.
// Assumes: One command a cycle from the bench; each is replayed one edge later on the pins.
// Notes: Released write data shows its inverse, so a stale value never looks valid.
`timescale 1ns/1ps
`default_nettype none
module rmt_cpu_model (
    input wire logic clock,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_sel,
    input wire logic [15:0] cmd_addr,
    input wire logic [15:0] cmd_data,
    output logic notify_wr,
    output logic [7:0] notify_wdata,
    output logic key_wr,
    output logic [7:0] key_wdata,
    output logic mode_wr,
    output logic [7:0] mode_wdata,
    output logic inv_wr,
    output logic [15:0] inv_wdata,
    output logic irq_flag_clr,
    output logic ram_req,
    output logic ram_we,
    output logic [15:0] ram_addr,
    output logic [7:0] ram_wdata
);
    logic [4:0] stb_q;
    logic [15:0] wdata_q;
    logic ram_cmd;

    assign ram_cmd = cmd_valid && (cmd_sel[2:1] == 2'b11);
    assign {irq_flag_clr, inv_wr, mode_wr, key_wr, notify_wr} = stb_q;
    assign notify_wdata = wdata_q[7:0];
    assign key_wdata = wdata_q[7:0];
    assign mode_wdata = wdata_q[7:0];
    assign inv_wdata = wdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Selects 0 to 4 pulse one register strobe for a single cycle.
    always_ff @(posedge clock) begin
        if (cmd_valid && cmd_sel <= 3'h4) begin
            stb_q <= 5'h01 << cmd_sel;
            wdata_q <= cmd_data;
        end else begin
            stb_q <= 5'h00;
            wdata_q <= ~cmd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Select 6 writes and select 7 reads the RAM, one access a cycle.
    always_ff @(posedge clock) begin
        ram_req <= ram_cmd;
        ram_we <= ram_cmd && !cmd_sel[0];
        if (ram_cmd) begin
            ram_addr <= cmd_addr;
            ram_wdata <= cmd_data[7:0];
        end else begin
            ram_addr <= ~cmd_addr;
            ram_wdata <= ~cmd_data[7:0];
        end
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench of the RAM ECC test-mode block.
// Assumes: The CPU model replays every bench command on the pins; ce is dropped once.
// Notes: Type and address are expected to hold unless an error was reported.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock, rst, ce, cmd_valid;
    logic [2:0] cmd_sel;
    logic [15:0] cmd_addr, cmd_data;
    wire logic notify_wr, key_wr, mode_wr, inv_wr, irq_flag_clr, ram_req, ram_we;
    wire logic [7:0] notify_wdata, key_wdata, mode_wdata, ram_wdata;
    wire logic [15:0] inv_wdata, ram_addr;
    wire logic [7:0] ram_rdata_q, data_invert_mask_q;
    wire logic ram_rvalid_q, single_err_notify_en_q, parity_invert_q, double_error_flag_q;
    wire logic ram_error_irq_flag_q, ram_error_request_q;
    wire logic [2:0] test_protect_key_q, test_mode_code_q;
    wire logic [3:0] check_code_invert_mask_q;
    wire logic [15:0] error_address_reg_q;
    logic [7:0] q, d;
    logic v, r, last_type;
    logic [15:0] last_addr, a;
    int fail_count, n_tests;
    logic [12:0] masks [10] = '{13'h0000, 13'h0008, 13'h0008, 13'h0100, 13'h1000,
                               13'h0003, 13'h0201, 13'h1010, 13'h0300, 13'h1800};
    // Per case: notify enable, request expected, double expected, read data trustworthy.
    logic [3:0] flags [10] = '{4'h9, 4'hD, 4'h1, 4'hD, 4'h9, 4'h6, 4'hE, 4'h7, 4'hE, 4'h7};
    rmt_ram_ecc_test #(.IDX_W(4), .ADDR_W(16)) rmt_ram_ecc_test_i (.clock, .rst, .ce,
        .notify_wr, .notify_wdata, .key_wr, .key_wdata, .mode_wr, .mode_wdata, .inv_wr,
        .inv_wdata, .irq_flag_clr, .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_rdata_q,
        .ram_rvalid_q, .single_err_notify_en_q, .test_protect_key_q, .test_mode_code_q,
        .data_invert_mask_q, .check_code_invert_mask_q, .parity_invert_q,
        .double_error_flag_q, .error_address_reg_q, .ram_error_irq_flag_q,
        .ram_error_request_q);
    rmt_cpu_model rmt_cpu_model_i (.clock, .cmd_valid, .cmd_sel, .cmd_addr, .cmd_data,
        .notify_wr, .notify_wdata, .key_wr, .key_wdata, .mode_wr, .mode_wdata, .inv_wr,
        .inv_wdata, .irq_flag_clr, .ram_req, .ram_we, .ram_addr, .ram_wdata);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // The block takes a command two edges after it is posted; results stand 1 ns later.
    task automatic op(input logic [2:0] sel, input logic [15:0] ad, input logic [15:0] dt);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_sel <= sel;
        cmd_addr <= ad;
        cmd_data <= dt;
        @(posedge clock);
        cmd_valid <= 1'b0;
        @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [2:0] sel, input logic [15:0] dt);
        op(sel, 16'h0000, dt);
    endtask
    task automatic ram(input logic we, input logic [15:0] ad, input logic [7:0] dt);
        op({2'b11, !we}, ad, {8'h00, dt});
        {q, v, r} = {ram_rdata_q, ram_rvalid_q, ram_error_request_q};
    endtask
    // Nothing else reaches the RAM while test mode is open, and no interrupt is serviced.
    task automatic corrupt(input logic en, input logic [12:0] mask);
        wr(3'h0, {15'h0000, en});
        wr(3'h1, 16'h0007);
        wr(3'h2, 16'h0001);
        wr(3'h3, {3'h0, mask});
        ram(1'b1, a, d);
        wr(3'h3, 16'h0000);
        wr(3'h2, 16'h0000);
        wr(3'h1, 16'h0000);
    endtask
    task automatic restore();
        ram(1'b1, a, d);
        wr(3'h4, 16'h0001);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        #1000000;
        fail_count++;
        summarize();
    end
    initial begin
        {cmd_valid, cmd_sel, cmd_addr, cmd_data} = 36'h000000000;
        {fail_count, n_tests, rst, ce, last_addr, last_type} = {32'd0, 32'd0, 2'b11, 17'h00000};
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        #1;
        chk({test_mode_code_q, test_protect_key_q, 10'(ram_error_irq_flag_q)}, 16'h0000);
        chk(error_address_reg_q, 16'h0000);
        // With the clock enable low a strobe and a read must leave no trace.
        @(posedge clock);
        ce <= 1'b0;
        wr(3'h0, 16'h0001);
        ram(1'b0, 16'h0000, 8'h00);
        chk({14'h0000, v, single_err_notify_en_q}, 16'h0000);
        @(posedge clock);
        ce <= 1'b1;
        wr(3'h2, 16'h0001);
        chk(16'(test_mode_code_q), 16'h0000);
        wr(3'h1, 16'h0007);
        chk(16'(test_protect_key_q), 16'h0007);
        wr(3'h2, 16'h0001);
        chk(16'(test_mode_code_q), 16'h0001);
        wr(3'h1, 16'h0000);
        wr(3'h2, 16'h0000);
        chk(16'(test_mode_code_q), 16'h0001);
        wr(3'h1, 16'h0007);
        wr(3'h2, 16'h0000);
        chk(16'(test_mode_code_q), 16'h0000);
        wr(3'h1, 16'h0000);
        wr(3'h0, 16'h00FF);
        chk(16'(single_err_notify_en_q), 16'h0001);
        wr(3'h0, 16'h00FE);
        chk(16'(single_err_notify_en_q), 16'h0000);
        wr(3'h3, 16'hFFFF);
        chk({3'h0, parity_invert_q, check_code_invert_mask_q, data_invert_mask_q},
            16'h1FFF);
        // A live inversion mask outside test mode must not touch stored words.
        ram(1'b1, 16'h0042, 8'hC3);
        ram(1'b0, 16'h0042, 8'h00);
        chk({6'h00, v, r, q}, 16'h02C3);
        wr(3'h3, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            a = 16'hA5F0 + 16'(i);
            d = 8'h5A + 8'(i * 37);
            corrupt(flags[i][3], masks[i]);
            ram(1'b0, a, 8'h00);
            chk({14'h0000, v, r}, {15'h0001, flags[i][2]});
            if (flags[i][0]) begin
                chk(16'(q), 16'(d));
            end
            if (flags[i][2]) begin
                {last_addr, last_type} = {a, flags[i][1]};
            end
            @(posedge clock);
            #1 chk({14'h0000, ram_rvalid_q, ram_error_request_q}, 16'h0000);
            @(posedge clock);
            #1 chk(16'(ram_error_irq_flag_q), 16'(flags[i][2]));
            chk(error_address_reg_q, last_addr);
            chk(16'(double_error_flag_q), 16'(last_type));
            restore();
            chk(16'(ram_error_irq_flag_q), 16'h0000);
            ram(1'b0, a, 8'h00);
            chk({7'h00, r, q}, {8'h00, d});
        end
        summarize();
    end
endmodule
`default_nettype wire
